// [hdl/tlic_pkg.sv]
// package for the two-level interrupt controller: addresses, layouts, reset values, carriers
package tlic_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NSRC = 12;
  localparam int HALF = 6;
  localparam int IDX_W = 4;
  localparam int ST_W = 3;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PRI_EN = 8'hE8;
  localparam logic [7:0] ADDR_EXT_EN = 8'hE6;
  localparam logic [7:0] ADDR_PRI_PRIO = 8'hB8;
  localparam logic [7:0] ADDR_EXT_PRIO = 8'hF6;
  localparam logic [7:0] ADDR_PEND_LO = 8'hD8;
  localparam logic [7:0] ADDR_PEND_HI = 8'hD9;
  localparam logic [7:0] ADDR_STATUS = 8'hDA;
  localparam logic [7:0] ADDR_MASK = 8'hDB;

  // ---------------------------------------------------------------
  // field layouts and reset values
  // ---------------------------------------------------------------
  localparam int GEN_BIT = 7;
  localparam logic [7:0] PRI_EN_WMASK = 8'hBF;
  localparam logic [7:0] LOW6_WMASK = 8'h3F;
  localparam logic [7:0] EXT_PRIO_TOP = 8'hC0;
  localparam logic [7:0] EXT_PRIO_RESET = 8'hC0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [NSRC-1:0] AUTOCLR_SRC = 12'h003;
  localparam int ST_PREEMPT = 0;
  localparam int ST_LATE = 1;
  localparam int ST_REENTRY = 2;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef logic [NSRC-1:0] tlic_src_t;
  typedef logic [IDX_W-1:0] tlic_idx_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tlic_bus_s;

  typedef struct packed {
    logic instr_done;
    logic instr_multi;
    logic vec_ack;
    logic return_from_interrupt_done;
  } tlic_core_s;

endpackage

// [hdl/tlic_arbiter.sv]
// fixed-order finder: lowest-numbered set request wins
module tlic_arbiter (
  // request vector
  input wire tlic_pkg::tlic_src_t req,
  // result
  output logic found,
  output tlic_pkg::tlic_idx_t idx
);

  logic [tlic_pkg::NSRC:0] seen;
  tlic_pkg::tlic_idx_t part [tlic_pkg::NSRC+1];

  assign seen[0] = 1'b0;
  assign part[0] = '0;

  // ---------------------------------------------------------------
  // per-source chain
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < tlic_pkg::NSRC; i++) begin : g_src
      wire first = req[i] & ~seen[i];
      assign seen[i+1] = seen[i] | req[i];
      assign part[i+1] = part[i] | (first ? tlic_pkg::tlic_idx_t'(i) : '0);
    end
  endgenerate

  assign found = seen[tlic_pkg::NSRC];
  assign idx = part[tlic_pkg::NSRC];

endmodule // tlic_arbiter

// [hdl/tlic_ctrl.sv]
// two-level interrupt controller: pending flags, enables, priorities, vectoring
// Behaviour
// RQ1 - twelve sources, each given low or high priority
// RQ2 - a source event sets its pending flag
// RQ3 - pending flags set regardless of any enable
// RQ4 - disabled sources raise no request; execution goes on
// RQ5 - enabled pending source vectors the core at instruction completion
// RQ6 - routine ends with return_from_interrupt; core resumes the next instruction
// RQ7 - each source has its own enable bit
// RQ8 - global_irq_enable, bit 7 of primary enable, gates all sources
// RQ9 - clear then single-cycle instruction may still take; multi-cycle never
// RQ10 - software puts a two-byte instruction after clearing an enable
// RQ11 - some flags auto-clear on vectoring; software clears the rest
// RQ12 - flag still set after return re-enters after one more instruction
// RQ13 - extended priority at 0xF6; top two bits read 11, ignore writes
// RQ14 - bit 5 comparator rise, bit 4 comparator fall priority
// RQ15 - bits 3..0 counter, conversion, window, two-wire priority
// RQ16 - high preempts low; low waits; fixed order within a level
// RQ17 - reset clears enables and priorities
module tlic_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire tlic_pkg::tlic_bus_s bus,
  output logic [7:0] rdata,
  // interrupt sources, one-cycle event pulses
  input wire tlic_pkg::tlic_src_t src_event,
  // processor core
  input wire tlic_pkg::tlic_core_s core,
  output logic vec_req,
  output tlic_pkg::tlic_idx_t vec_index,
  output logic vec_high,
  // controller event interrupt
  output logic irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] pri_en_reg, pri_en_next;
  logic [7:0] ext_en_reg, ext_en_next;
  logic [7:0] pri_prio_reg, pri_prio_next;
  logic [7:0] ext_prio_reg, ext_prio_next;
  tlic_pkg::tlic_src_t pend_reg, pend_next;
  tlic_pkg::tlic_src_t shadow_en_reg;
  logic shadow_valid_reg;
  logic return_from_interrupt_hold_reg;
  logic in_low_reg, in_high_reg;
  logic [tlic_pkg::ST_W-1:0] status_reg, status_next, mask_reg;
  logic vec_req_reg, vec_high_reg, irq_reg;
  tlic_pkg::tlic_idx_t vec_idx_reg;
  logic [7:0] rdata_reg;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire wr_pri_en = bus.wr && bus.addr == tlic_pkg::ADDR_PRI_EN;
  wire wr_ext_en = bus.wr && bus.addr == tlic_pkg::ADDR_EXT_EN;
  wire wr_pri_prio = bus.wr && bus.addr == tlic_pkg::ADDR_PRI_PRIO;
  wire wr_ext_prio = bus.wr && bus.addr == tlic_pkg::ADDR_EXT_PRIO;
  wire wr_pend_lo = bus.wr && bus.addr == tlic_pkg::ADDR_PEND_LO;
  wire wr_pend_hi = bus.wr && bus.addr == tlic_pkg::ADDR_PEND_HI;
  wire wr_status = bus.wr && bus.addr == tlic_pkg::ADDR_STATUS;
  wire wr_mask = bus.wr && bus.addr == tlic_pkg::ADDR_MASK;

  // writable bits only; top of extended priority stays 11
  assign pri_en_next = wr_pri_en ? (bus.wdata & tlic_pkg::PRI_EN_WMASK) : pri_en_reg;
  assign ext_en_next = wr_ext_en ? (bus.wdata & tlic_pkg::LOW6_WMASK) : ext_en_reg;
  assign pri_prio_next = wr_pri_prio ? (bus.wdata & tlic_pkg::LOW6_WMASK) : pri_prio_reg;
  assign ext_prio_next = wr_ext_prio ?
    ((bus.wdata & tlic_pkg::LOW6_WMASK) | tlic_pkg::EXT_PRIO_TOP) : ext_prio_reg; // see RQ13

  // ---------------------------------------------------------------
  // enable and priority vectors
  // ---------------------------------------------------------------
  // per-source enables count only under the global enable
  wire [tlic_pkg::NSRC-1:0] en_live = {ext_en_reg[tlic_pkg::HALF-1:0],
    pri_en_reg[tlic_pkg::HALF-1:0]} & {tlic_pkg::NSRC{pri_en_reg[tlic_pkg::GEN_BIT]}}; // see RQ7 see RQ8
  wire [tlic_pkg::NSRC-1:0] en_after = {ext_en_next[tlic_pkg::HALF-1:0],
    pri_en_next[tlic_pkg::HALF-1:0]} & {tlic_pkg::NSRC{pri_en_next[tlic_pkg::GEN_BIT]}};
  wire en_cleared = |(en_live & ~en_after);
  // sources 6..11 map to extended priority bits 0..5: two-wire, window,
  // conversion, counter array, comparator fall, comparator rise
  wire [tlic_pkg::NSRC-1:0] prio_high = {ext_prio_reg[tlic_pkg::HALF-1:0],
    pri_prio_reg[tlic_pkg::HALF-1:0]}; // see RQ1 see RQ14 see RQ15

  // a single-cycle instruction after an enable clear still sees the old
  // enables; software avoids this with a two-byte instruction
  wire use_shadow = shadow_valid_reg && !core.instr_multi; // see RQ9 see RQ10
  wire [tlic_pkg::NSRC-1:0] en_use = use_shadow ? shadow_en_reg : en_live;

  // ---------------------------------------------------------------
  // arbitration
  // ---------------------------------------------------------------
  wire [tlic_pkg::NSRC-1:0] cand = pend_reg & en_use; // see RQ4
  wire [tlic_pkg::NSRC-1:0] req_h = cand & prio_high;
  wire [tlic_pkg::NSRC-1:0] req_l = cand & ~prio_high;
  logic found_h, found_l;
  tlic_pkg::tlic_idx_t idx_h, idx_l;

  tlic_arbiter u_arb_high (
    .req(req_h),
    .found(found_h),
    .idx(idx_h)
  );

  tlic_arbiter u_arb_low (
    .req(req_l),
    .found(found_l),
    .idx(idx_l)
  );

  // high may nest into low; low waits for any routine to finish
  wire take_h = found_h && !in_high_reg; // see RQ16
  wire take_l = found_l && !in_high_reg && !in_low_reg; // see RQ16
  // decisions only at an instruction boundary, never in the one right after a return
  wire take = core.instr_done && !vec_req_reg && !return_from_interrupt_hold_reg && (take_h || take_l); // see RQ5 see RQ12
  wire tlic_pkg::tlic_idx_t sel_idx = take_h ? idx_h : idx_l;
  wire acked = vec_req_reg && core.vec_ack;

  // ---------------------------------------------------------------
  // pending flags and events
  // ---------------------------------------------------------------
  wire [tlic_pkg::NSRC-1:0] w1c_pend = {
    wr_pend_hi ? bus.wdata[tlic_pkg::NSRC-9:0] : 4'h0,
    wr_pend_lo ? bus.wdata : 8'h00};
  wire [tlic_pkg::NSRC-1:0] vec_onehot = tlic_pkg::tlic_src_t'(1) << vec_idx_reg;
  wire [tlic_pkg::NSRC-1:0] auto_clr = acked ? (vec_onehot & tlic_pkg::AUTOCLR_SRC) : '0; // see RQ11
  // a new event wins over any clear in the same cycle
  assign pend_next = (pend_reg & ~w1c_pend & ~auto_clr) | src_event; // see RQ2 see RQ3

  wire [tlic_pkg::ST_W-1:0] st_ev;
  assign st_ev[tlic_pkg::ST_PREEMPT] = take && take_h && in_low_reg;
  assign st_ev[tlic_pkg::ST_LATE] = take && use_shadow && !en_live[sel_idx];
  assign st_ev[tlic_pkg::ST_REENTRY] = core.return_from_interrupt_done && |(pend_reg & en_live); // see RQ12
  wire [tlic_pkg::ST_W-1:0] w1c_st = wr_status ? bus.wdata[tlic_pkg::ST_W-1:0] : '0;
  assign status_next = (status_reg & ~w1c_st) | st_ev;
  // irq follows a mask write at once, not one cycle after it
  wire [tlic_pkg::ST_W-1:0] mask_next = wr_mask ? bus.wdata[tlic_pkg::ST_W-1:0] : mask_reg;

  // ---------------------------------------------------------------
  // read mux; unmapped addresses read zero
  // ---------------------------------------------------------------
  wire [7:0] rd_mux =
    (bus.addr == tlic_pkg::ADDR_PRI_EN) ? pri_en_reg :
    (bus.addr == tlic_pkg::ADDR_EXT_EN) ? ext_en_reg :
    (bus.addr == tlic_pkg::ADDR_PRI_PRIO) ? pri_prio_reg :
    (bus.addr == tlic_pkg::ADDR_EXT_PRIO) ? ext_prio_reg :
    (bus.addr == tlic_pkg::ADDR_PEND_LO) ? pend_reg[7:0] :
    (bus.addr == tlic_pkg::ADDR_PEND_HI) ? {4'h0, pend_reg[tlic_pkg::NSRC-1:8]} :
    (bus.addr == tlic_pkg::ADDR_STATUS) ? {5'h00, status_reg} :
    (bus.addr == tlic_pkg::ADDR_MASK) ? {5'h00, mask_reg} : tlic_pkg::REG_RESET;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pri_en_reg <= tlic_pkg::REG_RESET; // see RQ17
      ext_en_reg <= tlic_pkg::REG_RESET;
      pri_prio_reg <= tlic_pkg::REG_RESET;
      ext_prio_reg <= tlic_pkg::EXT_PRIO_RESET;
      pend_reg <= '0;
      status_reg <= '0;
      mask_reg <= '0;
      irq_reg <= 1'b0;
      rdata_reg <= tlic_pkg::REG_RESET;
    end else begin
      pri_en_reg <= pri_en_next;
      ext_en_reg <= ext_en_next;
      pri_prio_reg <= pri_prio_next;
      ext_prio_reg <= ext_prio_next;
      pend_reg <= pend_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      irq_reg <= |(status_next & mask_next);
      rdata_reg <= bus.rd ? rd_mux : tlic_pkg::REG_RESET;
    end
  end

  // shadow of the enables from before a clearing write; a write in the
  // finishing cycle still counts for the next boundary
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shadow_valid_reg <= 1'b0;
      shadow_en_reg <= '0;
    end else if (en_cleared) begin
      shadow_valid_reg <= 1'b1; // see RQ9
      shadow_en_reg <= en_live;
    end else if (core.instr_done) begin
      shadow_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      return_from_interrupt_hold_reg <= 1'b0;
    end else if (core.return_from_interrupt_done) begin
      return_from_interrupt_hold_reg <= 1'b1; // see RQ12
    end else if (core.instr_done) begin
      return_from_interrupt_hold_reg <= 1'b0;
    end
  end

  // vector request stands until the core takes the call
  always_ff @(posedge core_clk) begin
    if (rst) begin
      vec_req_reg <= 1'b0;
      vec_idx_reg <= '0;
      vec_high_reg <= 1'b0;
    end else if (take) begin
      vec_req_reg <= 1'b1; // see RQ5
      vec_idx_reg <= sel_idx;
      vec_high_reg <= take_h;
    end else if (acked) begin
      vec_req_reg <= 1'b0;
    end
  end

  // in-service levels; a return closes the highest open level
  always_ff @(posedge core_clk) begin
    if (rst) begin
      in_low_reg <= 1'b0;
      in_high_reg <= 1'b0;
    end else if (acked) begin
      in_high_reg <= in_high_reg | vec_high_reg;
      in_low_reg <= in_low_reg | ~vec_high_reg;
    end else if (core.return_from_interrupt_done) begin
      in_high_reg <= 1'b0; // see RQ6
      in_low_reg <= in_high_reg & in_low_reg;
    end
  end

  assign rdata = rdata_reg;
  assign vec_req = vec_req_reg;
  assign vec_index = vec_idx_reg;
  assign vec_high = vec_high_reg;
  assign irq = irq_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_pend_set;
    @(posedge core_clk) disable iff (rst)
      (src_event != '0) |=> ((pend_reg & $past(src_event)) == $past(src_event));
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("event lost"); // see RQ2 see RQ3

  property p_no_req_disabled;
    @(posedge core_clk) disable iff (rst)
      $rose(vec_req_reg) |-> $past(en_use[sel_idx] && pend_reg[sel_idx]);
  endproperty
  a_no_req_disabled: assert property (p_no_req_disabled) else $error("disabled request"); // see RQ4 see RQ8

  property p_req_at_boundary;
    @(posedge core_clk) disable iff (rst)
      $rose(vec_req_reg) |-> $past(core.instr_done) && !$past(return_from_interrupt_hold_reg);
  endproperty
  a_req_at_boundary: assert property (p_req_at_boundary) else $error("off boundary"); // see RQ5

  property p_ack_drops;
    @(posedge core_clk) disable iff (rst)
      acked |=> !vec_req_reg ##1 !(in_low_reg == 1'b0 && in_high_reg == 1'b0 && $past(acked, 2));
  endproperty
  a_ack_drops: assert property (p_ack_drops) else $error("ack not handled"); // see RQ5 see RQ6

  property p_hold_after_return_from_interrupt;
    @(posedge core_clk) disable iff (rst)
      core.return_from_interrupt_done && !vec_req_reg |=> !vec_req_reg;
  endproperty
  a_hold_after_return_from_interrupt: assert property (p_hold_after_return_from_interrupt) else $error("re-entry early"); // see RQ12

  property p_autoclr;
    @(posedge core_clk) disable iff (rst)
      acked && tlic_pkg::AUTOCLR_SRC[vec_idx_reg] && !src_event[vec_idx_reg]
        |=> !pend_reg[$past(vec_idx_reg)];
  endproperty
  a_autoclr: assert property (p_autoclr) else $error("flag not auto-cleared"); // see RQ11

  property p_ext_top;
    @(posedge core_clk) disable iff (rst)
      bus.rd && bus.addr == tlic_pkg::ADDR_EXT_PRIO |=> rdata[7:6] == 2'b11;
  endproperty
  a_ext_top: assert property (p_ext_top) else $error("priority top bits wrong"); // see RQ13

  property p_preempt;
    @(posedge core_clk) disable iff (rst)
      $rose(vec_req_reg) && (in_low_reg || in_high_reg) |-> vec_high_reg && !in_high_reg;
  endproperty
  a_preempt: assert property (p_preempt) else $error("bad nesting"); // see RQ16

  property p_multi_blocks;
    @(posedge core_clk) disable iff (rst)
      core.instr_done && core.instr_multi && !vec_req_reg && !found_h && !found_l |=> !vec_req_reg;
  endproperty
  a_multi_blocks: assert property (p_multi_blocks) else $error("late take after multi"); // see RQ9

  property p_reset;
    @(posedge core_clk) rst |=> pri_en_reg == '0 && ext_en_reg == '0 && !vec_req_reg;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong"); // see RQ17

endmodule // tlic_ctrl

// [tb/tlic_core_model.sv]
// processor core stand-in: instruction boundaries, vector calls and returns
module tlic_core_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // commands from the bench
  input wire logic run,
  input wire logic step,
  input wire logic multi,
  input wire logic slow,
  input wire logic ret_cmd,
  // controller side
  input wire logic vec_req,
  output tlic_pkg::tlic_core_s core
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_reg;
  logic [1:0] ack_cnt_reg;
  logic acked_reg;
  logic ret_pend_reg;
  // pulses fall back to zero each cycle; a return never shares a cycle with a boundary
  always_ff @(posedge core_clk) begin
    core <= '0;
    if (rst) begin
      cnt_reg <= 2'h0;
      ack_cnt_reg <= 2'h0;
      acked_reg <= 1'b0;
      ret_pend_reg <= 1'b0;
    end else begin
      if (ret_pend_reg && cnt_reg == 2'h0) begin
        core.return_from_interrupt_done <= 1'b1;
        ret_pend_reg <= 1'b0;
        cnt_reg <= 2'h1;
      end else if (cnt_reg != 2'h0) begin
        cnt_reg <= cnt_reg - 2'h1;
      end else if (run || step) begin
        core.instr_done <= 1'b1;
        core.instr_multi <= multi;
        cnt_reg <= multi ? 2'h2 : 2'h0;
      end
      if (ret_cmd) begin
        ret_pend_reg <= 1'b1;
      end
      if (!vec_req) begin
        acked_reg <= 1'b0;
        ack_cnt_reg <= slow ? 2'h3 : 2'h0;
      end else if (!acked_reg) begin
        if (ack_cnt_reg == 2'h0) begin
          core.vec_ack <= 1'b1;
          acked_reg <= 1'b1;
        end else begin
          ack_cnt_reg <= ack_cnt_reg - 2'h1;
        end
      end
    end
  end
endmodule // tlic_core_model

// [tb/testbench.sv]
// self-checking bench for the two-level interrupt controller
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  tlic_pkg::tlic_bus_s bus = '0;
  tlic_pkg::tlic_src_t src_event = '0;
  tlic_pkg::tlic_core_s core;
  logic run = 1'b0;
  logic step = 1'b0;
  logic multi = 1'b0;
  logic slow = 1'b0;
  logic ret_cmd = 1'b0;
  logic [7:0] rdata;
  logic vec_req;
  logic vec_high;
  logic irq;
  tlic_pkg::tlic_idx_t vec_index;
  int n_mismatch = 0;
  int num_checks = 0;

  always #20 core_clk = ~core_clk;

  tlic_ctrl dut_u (.core_clk(core_clk), .rst(rst), .bus(bus), .rdata(rdata),
    .src_event(src_event), .core(core), .vec_req(vec_req), .vec_index(vec_index),
    .vec_high(vec_high), .irq(irq));
  tlic_core_model core_u (.core_clk(core_clk), .rst(rst), .run(run), .step(step),
    .multi(multi), .slow(slow), .ret_cmd(ret_cmd), .vec_req(vec_req), .core(core));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    @(negedge core_clk);
    chk("rdata", {4'h0, exp}, {4'h0, rdata});
  endtask

  task automatic ev(input tlic_pkg::tlic_src_t m);
    @(posedge core_clk);
    src_event <= m;
    @(posedge core_clk);
    src_event <= '0;
  endtask

  task automatic ret;
    @(posedge core_clk);
    ret_cmd <= 1'b1;
    @(posedge core_clk);
    ret_cmd <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic step_i(input logic m);
    @(posedge core_clk);
    step <= 1'b1;
    multi <= m;
    @(posedge core_clk);
    step <= 1'b0;
    multi <= 1'b0;
  endtask

  // waits for a request, judges it, then lets the core's call go through
  task automatic wait_req(input int idx, input logic hi);
    int n;
    n = 0;
    while (vec_req !== 1'b1 && n < 30) begin
      @(negedge core_clk);
      n++;
    end
    chk("vec_req", 12'h001, {11'h0, vec_req});
    chk("vec_index", 12'(idx), {8'h0, vec_index});
    chk("vec_high", {11'h0, hi}, {11'h0, vec_high});
    repeat (8) @(negedge core_clk);
  endtask

  task automatic no_req(input int n);
    repeat (n) begin
      @(negedge core_clk);
      chk("idle vec_req", 12'h000, {11'h0, vec_req});
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    rd(tlic_pkg::ADDR_EXT_PRIO, 8'hC0);
    rd(tlic_pkg::ADDR_PRI_EN, 8'h00);
    rd(tlic_pkg::ADDR_PRI_PRIO, 8'h00);
    wr(tlic_pkg::ADDR_EXT_PRIO, 8'h3F);
    rd(tlic_pkg::ADDR_EXT_PRIO, 8'hFF);
    wr(tlic_pkg::ADDR_EXT_PRIO, 8'h00);
    rd(tlic_pkg::ADDR_EXT_PRIO, 8'hC0);
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h00);
    $display("test regs done");
  endtask

  task automatic t_disabled;
    ev(12'h008);
    rd(tlic_pkg::ADDR_PEND_LO, 8'h08);
    no_req(10);
    wr(tlic_pkg::ADDR_PRI_EN, 8'h08);
    no_req(10);
    wr(tlic_pkg::ADDR_PRI_EN, 8'h88);
    wait_req(3, 1'b0);
    rd(tlic_pkg::ADDR_PEND_LO, 8'h08);
    wr(tlic_pkg::ADDR_PEND_LO, 8'h08);
    ret();
    $display("test disabled done");
  endtask

  task automatic t_autoclr;
    wr(tlic_pkg::ADDR_PRI_EN, 8'h81);
    ev(12'h009);
    wait_req(0, 1'b0);
    rd(tlic_pkg::ADDR_PEND_LO, 8'h08);
    wr(tlic_pkg::ADDR_PEND_LO, 8'h08);
    ret();
    $display("test autoclear done");
  endtask

  task automatic t_reentry;
    wr(tlic_pkg::ADDR_MASK, 8'h00);
    wr(tlic_pkg::ADDR_STATUS, 8'h07);
    wr(tlic_pkg::ADDR_PRI_EN, 8'h88);
    ev(12'h008);
    wait_req(3, 1'b0);
    ret();
    wait_req(3, 1'b0);
    rd(tlic_pkg::ADDR_STATUS, 8'h04);
    chk("masked irq", 12'h000, {11'h0, irq});
    wr(tlic_pkg::ADDR_MASK, 8'h04);
    repeat (2) @(negedge core_clk);
    chk("irq", 12'h001, {11'h0, irq});
    wr(tlic_pkg::ADDR_STATUS, 8'h04);
    repeat (2) @(negedge core_clk);
    chk("cleared irq", 12'h000, {11'h0, irq});
    wr(tlic_pkg::ADDR_PEND_LO, 8'h08);
    ret();
    $display("test reentry done");
  endtask

  // slow core acks; a low routine is preempted, then the lower-numbered of two queued lows is taken first
  task automatic t_prio;
    slow <= 1'b1;
    wr(tlic_pkg::ADDR_STATUS, 8'h07);
    wr(tlic_pkg::ADDR_EXT_PRIO, 8'h20);
    wr(tlic_pkg::ADDR_EXT_EN, 8'h20);
    wr(tlic_pkg::ADDR_PRI_EN, 8'hB8);
    ev(12'h008);
    wait_req(3, 1'b0);
    ev(12'h030);
    no_req(10);
    ev(12'h800);
    wait_req(11, 1'b1);
    rd(tlic_pkg::ADDR_STATUS, 8'h01);
    wr(tlic_pkg::ADDR_PEND_LO, 8'h08);
    wr(tlic_pkg::ADDR_PEND_HI, 8'h08);
    ret();
    no_req(6);
    ret();
    wait_req(4, 1'b0);
    wr(tlic_pkg::ADDR_PEND_LO, 8'h30);
    ret();
    slow <= 1'b0;
    $display("test priority done");
  endtask

  // the core stops so that the only boundaries are the bench's steps, a single step after the first disabling write and a multi-cycle one after the last
  task automatic t_late;
    @(posedge core_clk);
    run <= 1'b0;
    wr(tlic_pkg::ADDR_STATUS, 8'h07);
    wr(tlic_pkg::ADDR_EXT_EN, 8'h00);
    wr(tlic_pkg::ADDR_PRI_EN, 8'h90);
    ev(12'h010);
    no_req(5);
    wr(tlic_pkg::ADDR_PRI_EN, 8'h10);
    step_i(1'b0);
    wait_req(4, 1'b0);
    rd(tlic_pkg::ADDR_STATUS, 8'h02);
    wr(tlic_pkg::ADDR_PRI_EN, 8'h90);
    ret();
    step_i(1'b0);
    no_req(4);
    step_i(1'b0);
    wait_req(4, 1'b0);
    rd(tlic_pkg::ADDR_STATUS, 8'h06);
    wr(tlic_pkg::ADDR_PEND_LO, 8'h10);
    ret();
    step_i(1'b0);
    wr(tlic_pkg::ADDR_PRI_EN, 8'h90);
    ev(12'h010);
    wr(tlic_pkg::ADDR_PRI_EN, 8'h10);
    step_i(1'b1);
    no_req(8);
    wr(tlic_pkg::ADDR_PEND_LO, 8'h10);
    $display("test late take done");
  endtask

  // a reset in mid-run must bring back the defaults and drop a pending flag
  task automatic t_reset;
    wr(tlic_pkg::ADDR_EXT_PRIO, 8'h15);
    wr(tlic_pkg::ADDR_PRI_EN, 8'h81);
    ev(12'h001);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd(tlic_pkg::ADDR_EXT_PRIO, 8'hC0);
    rd(tlic_pkg::ADDR_PRI_EN, 8'h00);
    rd(tlic_pkg::ADDR_PEND_LO, 8'h00);
    no_req(4);
    $display("test reset done");
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    run <= 1'b1;
    t_regs();
    t_disabled();
    t_autoclr();
    t_reentry();
    t_prio();
    t_late();
    t_reset();
    report_and_stop();
  end

  // the scenarios take well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule // testbench
